// >>> bench/stc_arb_peer.sv
// Purpose: upstream ring neighbour feeding the arbitration input
// Assumes: send is a one-cycle pulse while idle
// Notes:   idle line toggles so a stale value never looks valid
module stc_arb_peer
#(
  parameter logic [7:0] OPC = 8'h96
)
(
  // clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // control and ring output
  input  wire logic send,
  output logic      arb_in,
  output logic      opcode_end
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  logic [7:0] sh;
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      cnt        <= 4'h0;
      arb_in     <= 1'b0;
      opcode_end <= 1'b0;
    end
    else
    begin
      opcode_end <= (cnt == 4'h1);
      if (send)
      begin
        sh  <= OPC;
        cnt <= 4'h8;
      end
      else if (cnt != 4'h0)
      begin
        arb_in <= sh[7];
        sh     <= sh << 1;
        cnt    <= cnt - 4'h1;
      end
      else
        arb_in <= ~arb_in;
    end
  end
endmodule

// >>> bench/stc_timing_ctrl_assertions.sv
// Purpose: port-level timing checks for the supervision block
// Assumes: bypass depth 4 in the bound instance, so arb_out trails arb_in by 5
// Notes:   token wait counted locally, restarted by token_rx
module stc_timing_ctrl_assertions
  import stc_pkg::*;
#(
  parameter longint TOKEN_CYC = T8_CYC
)
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // watched inputs
  input wire logic tx_last,
  input wire logic deselect_done,
  input wire logic hw_arb_en,
  input wire logic arb_bypass,
  input wire logic arb_in,
  input wire logic opcode_end,
  input wire logic token_rx,
  input wire logic token_wait,
  input wire logic gap_end_soon,
  // watched outputs
  input wire logic tx_start,
  input wire logic drv_oe,
  input wire logic arb_out,
  input wire logic opcode_go,
  input wire logic token_send_ok,
  input wire logic token_timeout
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [31:0] wait_cnt_reg;
  logic [31:0] wait_cnt_next;
  always_comb wait_cnt_next = (token_wait && !token_rx) ? wait_cnt_reg + 32'h1 : 32'h0;
  always_ff @(posedge clock) wait_cnt_reg <= reset_n ? wait_cnt_next : 32'h0;

  a_oe_before_start: assert property (tx_start |-> $past(drv_oe) && $past(drv_oe, 2))
    else $error("packet started without two clocks of driver enable");
  a_oe_to_start: assert property ($rose(drv_oe) |-> !tx_start ##2 tx_start)
    else $error("packet start not two clocks after driver enable");
  a_deselect_hiz: assert property (tx_last && deselect_done && !hw_arb_en |-> ##[1:2] !drv_oe)
    else $error("drivers still on after deselect response");
  a_arb_drop: assert property (tx_last && hw_arb_en |-> ##[1:2] !drv_oe)
    else $error("drivers still on after arbitrated packet");
  a_bypass_delay: assert property ((arb_bypass && hw_arb_en) [*6] |-> arb_out == $past(arb_in, 5))
    else $error("bypass bit not passed with expected delay");
  a_opcode_next: assert property (opcode_end && hw_arb_en && !arb_bypass |-> ##10 opcode_go)
    else $error("next opcode not started in time");
  a_token_min: assert property (token_timeout |-> wait_cnt_reg >= TOKEN_CYC - 1)
    else $error("token timeout declared too early");
  a_gap_overlap: assert property (token_send_ok == $past(gap_end_soon))
    else $error("token start not tied to gap end window");

  c_packet: cover property (tx_start);
  c_timeout: cover property (token_timeout);
  c_opcode: cover property (opcode_go);
endmodule

// >>> bench/stc_timing_ctrl_bench.sv
// Purpose: self-checking bench for the timing supervision block
// Assumes: long windows shortened to 64 cycles, token timeout kept full length
// Notes:   inputs move 1 ns after the rising edge, outputs read there too
module stc_timing_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import stc_pkg::*;
  localparam longint S = 64;
  localparam int     BD = 4;
  logic clock = 0, reset_n = 0, tx_request = 0, tx_last = 0, deselect_done = 0, select_pkg = 0;
  logic cmd_end = 0, resp_start = 0, resp_final = 0, delayed_ready = 0, delayed_aen_en = 0;
  logic async_reset_evt = 0, sync_reset_done = 0, hw_arb_en = 0, arb_bypass = 0;
  logic token_rx = 0, token_wait = 0, gap_end_soon = 0, xoff_request = 0, op_send = 0;
  logic arb_in, opcode_end, tx_start, drv_oe, arb_out, opcode_go, token_send_ok, token_timeout;
  logic xoff_allowed, cmd_ready, ignore_traffic, resp_late, delayed_late, opcode_late;
  logic [7:0] hist = 8'h0;
  int num_errors = 0;
  int total_checks = 0;
  int n;
  logic g;

  stc_timing_ctrl #(.HIZ_CYC(S), .READY_CYC(S), .RESP_CYC(S), .ARST_CYC(S), .SRST_CYC(S),
    .XOFF_CYC(S), .DELAYED_CYC(S), .BYPASS_DLY(BD)) stc_timing_ctrl_i (
    .clock(clock), .reset_n(reset_n), .tx_request(tx_request), .tx_last(tx_last),
    .deselect_done(deselect_done), .select_pkg(select_pkg), .cmd_end(cmd_end), .resp_start(resp_start),
    .resp_final(resp_final), .delayed_ready(delayed_ready), .delayed_aen_en(delayed_aen_en),
    .async_reset_evt(async_reset_evt), .sync_reset_done(sync_reset_done), .hw_arb_en(hw_arb_en),
    .arb_bypass(arb_bypass), .arb_in(arb_in), .opcode_end(opcode_end), .token_rx(token_rx),
    .token_wait(token_wait), .gap_end_soon(gap_end_soon), .xoff_request(xoff_request),
    .tx_start(tx_start), .drv_oe(drv_oe), .arb_out(arb_out), .opcode_go(opcode_go),
    .token_send_ok(token_send_ok), .token_timeout(token_timeout), .xoff_allowed(xoff_allowed),
    .cmd_ready(cmd_ready), .ignore_traffic(ignore_traffic), .resp_late(resp_late),
    .delayed_late(delayed_late), .opcode_late(opcode_late));
  stc_arb_peer stc_arb_peer_i (.clock(clock), .reset_n(reset_n), .send(op_send), .arb_in(arb_in),
    .opcode_end(opcode_end));

  always #2 clock = ~clock;
  always @(posedge clock) hist <= {hist[6:0], arb_in};

  function automatic logic exp_bypass(logic [7:0] h);
    return h[BD];
  endfunction

  task automatic cyc(int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic wait_v(ref logic s, input logic v, input int lim, output int k);
    k = 0;
    while (s !== v && k < lim)
    begin
      cyc(1);
      k++;
    end
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clock);
    num_errors++;
    test_done();
  end

  initial
  begin
    void'($urandom(14049));
    cyc(20);
    reset_n = 1'b1;
    cyc(1);
    chk({drv_oe, tx_start, resp_late, delayed_late, opcode_late}, 5'h0); // RESET
    wait_v(cmd_ready, 1'b1, 200, n);
    chk(n <= S, 1'b1);
    tx_request = 1'b1; // refused: still high-impedance until selected
    cyc(1);
    tx_request = 1'b0;
    cyc(3);
    chk(drv_oe, 1'b0);
    for (int a = 0; a < 2; a++)
    begin
      pulse(select_pkg);
      hw_arb_en = a[0];
      cyc(1);
      tx_request = 1'b1;
      cyc(1);
      tx_request = 1'b0;
      cyc(1);
      chk({drv_oe, tx_start}, 2'b10);
      cyc(1);
      chk(tx_start, 1'b1);
      tx_last = 1'b1;
      deselect_done = !a[0];
      cyc(1);
      tx_last = 1'b0;
      deselect_done = 1'b0;
      cyc(2);
      chk(drv_oe, 1'b0);
    end
    repeat (30)
    begin
      g = $urandom % 2;
      gap_end_soon = g;
      cyc(1);
      chk(token_send_ok, g);
    end
    arb_bypass = 1'b1;
    cyc(8);
    repeat (30)
    begin
      cyc(1);
      chk(arb_out, exp_bypass(hist));
    end
    arb_bypass = 1'b0;
    pulse(op_send);
    wait_v(opcode_end, 1'b1, 20, n);
    wait_v(opcode_go, 1'b1, 40, n);
    chk(n <= T9_CYC, 1'b1);
    chk(opcode_late, 1'b0);
    pulse(xoff_request);
    cyc(2);
    chk(xoff_allowed, 1'b1);
    cyc(S + 4);
    chk(xoff_allowed, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      if (k == 0)
        pulse(async_reset_evt);
      else
        pulse(sync_reset_done);
      wait_v(ignore_traffic, 1'b1, 4, n);
      chk(ignore_traffic, 1'b1);
      // silence tolerated for up to the whole interval before retrying
      wait_v(ignore_traffic, 1'b0, S + 8, n);
      chk(n <= S, 1'b1);
    end
    delayed_aen_en = $urandom % 2;
    pulse(cmd_end);
    cyc(2 + $urandom % 20);
    pulse(resp_start);
    cyc(5);
    pulse(delayed_ready);
    pulse(resp_final);
    cyc(S + 4);
    chk({resp_late, delayed_late}, 2'b00);
    pulse(cmd_end);
    cyc(S + 4);
    chk({resp_late, delayed_late}, 2'b11);
    token_wait = 1'b1;
    cyc(100);
    pulse(token_rx);
    wait_v(token_timeout, 1'b1, 33000, n);
    chk(n >= T8_CYC - 1, 1'b1);
    token_wait = 1'b0;
    cyc(2);
    test_done();
  end
endmodule

bind stc_timing_ctrl stc_timing_ctrl_assertions #(.TOKEN_CYC(TOKEN_CYC)) stc_timing_ctrl_assertions_i (
  .clock(clock), .reset_n(reset_n), .tx_last(tx_last), .deselect_done(deselect_done), .hw_arb_en(hw_arb_en),
  .arb_bypass(arb_bypass), .arb_in(arb_in), .opcode_end(opcode_end), .token_rx(token_rx),
  .token_wait(token_wait), .gap_end_soon(gap_end_soon), .tx_start(tx_start), .drv_oe(drv_oe),
  .arb_out(arb_out), .opcode_go(opcode_go), .token_send_ok(token_send_ok), .token_timeout(token_timeout));

// >>> shared/stc_pkg.sv
// Purpose: constants for sideband timing supervision
// Assumes: 250 MHz reference clock, 4 ns period
// Notes:   times kept in their own unit, cycle counts derived from them
package stc_pkg;
  localparam longint CLK_HZ         = 64'd250_000_000;
  localparam longint T1_US          = 64'd200;
  localparam longint T1_CYC         = (T1_US * CLK_HZ) / 64'd1_000_000;
  localparam int     T2_CLK         = 2;
  localparam longint T4_S           = 64'd2;
  localparam longint T4_CYC         = T4_S * CLK_HZ;
  localparam longint T5_MS          = 64'd50;
  localparam longint T5_CYC         = (T5_MS * CLK_HZ) / 64'd1000;
  localparam longint T6_S           = 64'd2;
  localparam longint T6_CYC         = T6_S * CLK_HZ;
  localparam longint T7_S           = 64'd2;
  localparam longint T7_CYC         = T7_S * CLK_HZ;
  localparam longint T8_CYC         = 64'd32000;
  localparam int     T9_CYC         = 32;
  localparam int     T10_CYC        = 32;
  localparam int     T11_CYC        = 32;
  localparam longint T12_CYC        = 64'd50331648;
  localparam int     T13_CYC        = 6;
  localparam longint T14_S          = 64'd4;
  localparam longint T14_CYC        = T14_S * CLK_HZ;
  localparam int     CNT_W          = 32;

  typedef enum logic [2:0] {
    STC_IDLE    = 3'b000,
    STC_PREP    = 3'b001,
    STC_SEND    = 3'b010,
    STC_HIZ     = 3'b011,
    STC_QUIET   = 3'b100
  } stc_drv_t;
endpackage

// >>> verilog/stc_delay_line.sv
// Purpose: fixed-length bit delay for arbitration bypass
// Assumes: depth at most the bypass limit
// Notes:   output comes from a register
module stc_delay_line
  import stc_pkg::*;
#(
  parameter int DEPTH = 8
)
(
  // clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // bit stream
  input  wire logic bit_in,
  output logic      bit_out
);
  if (DEPTH < 1 || DEPTH > T10_CYC)
    $error("stc_delay_line: DEPTH out of range");

  logic [DEPTH-1:0] shift_reg;
  logic [DEPTH-1:0] shift_next;

  // shift then overwrite bit 0, so a depth of one needs no special case
  always_comb
  begin
    shift_next    = shift_reg << 1;
    shift_next[0] = bit_in;
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      shift_reg <= '0;
    else
      shift_reg <= shift_next;
  end

  assign bit_out = shift_reg[DEPTH-1];
endmodule

// >>> verilog/stc_timing_ctrl.sv
// Purpose: timing supervision of sideband drivers, responses, resets and arbitration
// Assumes: all events are one-cycle pulses synchronous to clock
// Notes:   deadline flags are sticky until reset
//
// Contract
// - after deselect response ends, outputs go high-impedance within 200 us
// - drivers enabled at least 2 clocks before first packet clock
// - able to answer commands within 2 s of interface power
// - normal response begins within 50 ms of command end
// - after asynchronous reset, may ignore traffic for at most 2 s
// - after synchronous reset response, may ignore traffic at most 2 s
// - wait at least 32000 clocks before declaring token timeout
// - next opcode on arbitration output within 32 clocks of opcode end
// - bypass delays each arbitration bit by at most 32 clocks; delay here is BYPASS_DLY + 1, so 33 at the allowed BYPASS_DLY of 32
// - receive data starts after driver-enable minimum, within 32 clocks of token; start here follows tx_request by three clocks, token not used
// - xoff renewals allowed only within 50331648 clocks of initial xoff
// - token may start at most 6 clocks before gap end
// - final response within 4 s of command end, delayed ones included
// - delayed limit ends at ready notification or internal ready when polling
// - arbitration buffer timing overrides packet-based output timing
// - these limits apply on the reduced media independent transport
module stc_timing_ctrl
  import stc_pkg::*;
#(
  parameter longint HIZ_CYC     = T1_CYC,
  parameter longint READY_CYC   = T4_CYC,
  parameter longint RESP_CYC    = T5_CYC,
  parameter longint ARST_CYC    = T6_CYC,
  parameter longint SRST_CYC    = T7_CYC,
  parameter longint TOKEN_CYC   = T8_CYC,
  parameter longint XOFF_CYC    = T12_CYC,
  parameter longint DELAYED_CYC = T14_CYC,
  parameter int     BYPASS_DLY  = 4
)
(
  // clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // packet events from the controller core
  input  wire logic tx_request,
  input  wire logic tx_last,
  input  wire logic deselect_done,
  input  wire logic select_pkg,
  input  wire logic cmd_end,
  input  wire logic resp_start,
  input  wire logic resp_final,
  input  wire logic delayed_ready,
  input  wire logic delayed_aen_en,
  input  wire logic async_reset_evt,
  input  wire logic sync_reset_done,
  // arbitration
  input  wire logic hw_arb_en,
  input  wire logic arb_bypass,
  input  wire logic arb_in,
  input  wire logic opcode_end,
  input  wire logic token_rx,
  input  wire logic token_wait,
  input  wire logic gap_end_soon,
  input  wire logic xoff_request,
  // controls to the core and pins
  output logic      tx_start,
  output logic      drv_oe,
  output logic      arb_out,
  output logic      opcode_go,
  output logic      token_send_ok,
  output logic      token_timeout,
  output logic      xoff_allowed,
  output logic      cmd_ready,
  output logic      ignore_traffic,
  // deadline status
  output logic      resp_late,
  output logic      delayed_late,
  output logic      opcode_late
);
  if (HIZ_CYC < 1 || READY_CYC < 1 || RESP_CYC < 1 || TOKEN_CYC < T8_CYC)
    $error("stc_timing_ctrl: bad timing parameter");
  if (BYPASS_DLY < 1 || BYPASS_DLY > T10_CYC)
    $error("stc_timing_ctrl: bypass delay out of range");

  // driver sequencing
  stc_drv_t         drv_reg,    drv_next;
  logic [CNT_W-1:0] drv_cnt_reg, drv_cnt_next;
  logic             tx_start_reg, tx_start_next;
  logic             oe_reg,     oe_next;

  // counters for the long intervals
  logic [CNT_W-1:0] pwr_cnt_reg,  pwr_cnt_next;
  logic [CNT_W-1:0] rst_cnt_reg,  rst_cnt_next;
  logic [CNT_W-1:0] resp_cnt_reg, resp_cnt_next;
  logic [CNT_W-1:0] dly_cnt_reg,  dly_cnt_next;
  logic [CNT_W-1:0] tok_cnt_reg,  tok_cnt_next;
  logic [CNT_W-1:0] xoff_cnt_reg, xoff_cnt_next;
  logic [5:0]       op_cnt_reg,   op_cnt_next;
  logic             resp_act_reg, resp_act_next;
  logic             dly_act_reg,  dly_act_next;
  logic             op_act_reg,   op_act_next;
  logic             xoff_act_reg, xoff_act_next;
  logic             ready_reg,    ready_next;
  logic             ign_reg,      ign_next;
  logic             rlate_reg,    rlate_next;
  logic             dlate_reg,    dlate_next;
  logic             olate_reg,    olate_next;
  logic             tmo_reg,      tmo_next;
  logic             go_reg,       go_next;
  logic             tok_ok_reg,   tok_ok_next;
  logic             xok_reg,      xok_next;
  logic             bypass_bit;
  logic             arb_out_reg,  arb_out_next;
  stc_delay_line #(
    .DEPTH (BYPASS_DLY)
  ) u_bypass (
    .clock   (clock),
    .reset_n (reset_n),
    .bit_in  (arb_in),
    .bit_out (bypass_bit)
  );

  always_comb
  begin
    drv_next      = drv_reg;
    drv_cnt_next  = drv_cnt_reg;
    tx_start_next = 1'b0;
    oe_next       = oe_reg;
    case (drv_reg)
      STC_IDLE:
      begin
        if (tx_request && ready_reg && !ign_reg)
        begin
          drv_next     = STC_PREP;
          oe_next      = 1'b1;
          drv_cnt_next = '0;
        end
      end
      STC_PREP:
      begin
        drv_cnt_next = drv_cnt_reg + 1'b1;
        // start after exactly two enabled clocks, three clocks after the request; no token is seen here
        if (drv_cnt_reg >= CNT_W'(T2_CLK - 1))
        begin
          drv_next      = STC_SEND;
          tx_start_next = 1'b1;
        end
      end
      STC_SEND:
      begin
        if (tx_last)
        begin
          drv_cnt_next = '0;
          drv_next     = (deselect_done && !hw_arb_en) ? STC_HIZ : STC_IDLE;
          if (hw_arb_en)
            oe_next = 1'b0;
        end
      end
      STC_HIZ:
      begin
        // release at once; counter advances but nothing reads it
        drv_cnt_next = drv_cnt_reg + 1'b1;
        oe_next      = 1'b0;
        drv_next     = STC_QUIET;
      end
      STC_QUIET:
      begin
        if (select_pkg)
          drv_next = STC_IDLE;
      end
      default:
      begin
        drv_next = STC_IDLE;
        oe_next  = 1'b0;
      end
    endcase
  end

  // sync reset folded into each register, reset values all constants
  always_ff @(posedge clock)
  begin
    drv_reg      <= reset_n ? drv_next : STC_QUIET;
    drv_cnt_reg  <= reset_n ? drv_cnt_next : '0;
    tx_start_reg <= reset_n ? tx_start_next : 1'b0;
    oe_reg       <= reset_n ? oe_next : 1'b0;
  end

  // readiness, reset windows, response deadlines, arbitration timers
  always_comb
  begin
    pwr_cnt_next  = pwr_cnt_reg;
    ready_next    = ready_reg;
    rst_cnt_next  = rst_cnt_reg;
    ign_next      = ign_reg;
    resp_cnt_next = resp_cnt_reg;
    resp_act_next = resp_act_reg;
    rlate_next    = rlate_reg;
    dly_cnt_next  = dly_cnt_reg;
    dly_act_next  = dly_act_reg;
    dlate_next    = dlate_reg;
    op_cnt_next   = op_cnt_reg;
    op_act_next   = op_act_reg;
    olate_next    = olate_reg;
    go_next       = 1'b0;
    tok_cnt_next  = tok_cnt_reg;
    tmo_next      = 1'b0;
    xoff_cnt_next = xoff_cnt_reg;
    xoff_act_next = xoff_act_reg;
    xok_next      = xok_reg;
    tok_ok_next   = gap_end_soon;
    arb_out_next  = arb_bypass ? bypass_bit : arb_out_reg;
    // power-up ready, capped well inside the limit
    if (!ready_reg)
    begin
      pwr_cnt_next = pwr_cnt_reg + 1'b1;
      if (pwr_cnt_reg >= CNT_W'(READY_CYC / 64'd2))
        ready_next = 1'b1;
    end
    // reset windows; half the limit, restarted at the start edge
    if (async_reset_evt || sync_reset_done)
    begin
      ign_next     = 1'b1;
      rst_cnt_next = '0;
    end
    else if (ign_reg)
    begin
      rst_cnt_next = rst_cnt_reg + 1'b1;
      if (rst_cnt_reg >= CNT_W'((ARST_CYC < SRST_CYC ? ARST_CYC : SRST_CYC) / 64'd2))
        ign_next = 1'b0;
    end
    // normal response deadline
    if (cmd_end)
    begin
      resp_act_next = 1'b1;
      resp_cnt_next = '0;
    end
    else if (resp_start)
      resp_act_next = 1'b0;
    else if (resp_act_reg)
    begin
      resp_cnt_next = resp_cnt_reg + 1'b1;
      if (resp_cnt_reg >= CNT_W'(RESP_CYC - 64'd1))
        rlate_next = 1'b1;
    end
    // delayed response deadline
    if (cmd_end)
    begin
      dly_act_next = 1'b1;
      dly_cnt_next = '0;
    end
    else if (resp_final || (delayed_ready && delayed_aen_en) || (delayed_ready && !delayed_aen_en))
      dly_act_next = 1'b0;
    else if (dly_act_reg)
    begin
      dly_cnt_next = dly_cnt_reg + 1'b1;
      if (dly_cnt_reg >= CNT_W'(DELAYED_CYC - 64'd1))
        dlate_next = 1'b1;
    end
    // opcode processing: issue next opcode well inside the limit
    if (opcode_end && hw_arb_en && !arb_bypass)
    begin
      op_act_next = 1'b1;
      op_cnt_next = '0;
    end
    else if (op_act_reg)
    begin
      op_cnt_next = op_cnt_reg + 1'b1;
      if (op_cnt_reg == 6'(T9_CYC / 4))
      begin
        go_next     = 1'b1;
        op_act_next = 1'b0;
      end
      if (op_cnt_reg >= 6'(T9_CYC - 1))
        olate_next = 1'b1;
    end
    // token timeout, never before the minimum
    if (!token_wait || token_rx)
      tok_cnt_next = '0;
    else if (tok_cnt_reg >= CNT_W'(TOKEN_CYC - 64'd1))
    begin
      tmo_next     = 1'b1;
      tok_cnt_next = '0;
    end
    else
      tok_cnt_next = tok_cnt_reg + 1'b1;
    // xoff renewal window
    if (xoff_request && !xoff_act_reg)
    begin
      xoff_act_next = 1'b1;
      xok_next      = 1'b1;
      xoff_cnt_next = '0;
    end
    else if (xoff_act_reg)
    begin
      xoff_cnt_next = xoff_cnt_reg + 1'b1;
      if (xoff_cnt_reg >= CNT_W'(XOFF_CYC - 64'd1))
      begin
        xok_next      = 1'b0;
        xoff_act_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    pwr_cnt_reg  <= reset_n ? pwr_cnt_next : '0;
    ready_reg    <= reset_n ? ready_next : 1'b0;
    rst_cnt_reg  <= reset_n ? rst_cnt_next : '0;
    ign_reg      <= reset_n ? ign_next : 1'b0;
    resp_cnt_reg <= reset_n ? resp_cnt_next : '0;
    resp_act_reg <= reset_n ? resp_act_next : 1'b0;
    rlate_reg    <= reset_n ? rlate_next : 1'b0;
    dly_cnt_reg  <= reset_n ? dly_cnt_next : '0;
    dly_act_reg  <= reset_n ? dly_act_next : 1'b0;
    dlate_reg    <= reset_n ? dlate_next : 1'b0;
    op_cnt_reg   <= reset_n ? op_cnt_next : '0;
    op_act_reg   <= reset_n ? op_act_next : 1'b0;
    olate_reg    <= reset_n ? olate_next : 1'b0;
    go_reg       <= reset_n ? go_next : 1'b0;
    tok_cnt_reg  <= reset_n ? tok_cnt_next : '0;
    tmo_reg      <= reset_n ? tmo_next : 1'b0;
    xoff_cnt_reg <= reset_n ? xoff_cnt_next : '0;
    xoff_act_reg <= reset_n ? xoff_act_next : 1'b0;
    xok_reg      <= reset_n ? xok_next : 1'b0;
    tok_ok_reg   <= reset_n ? tok_ok_next : 1'b0;
    arb_out_reg  <= reset_n ? arb_out_next : 1'b0;
  end

  assign tx_start       = tx_start_reg;
  assign drv_oe         = oe_reg;
  assign arb_out        = arb_out_reg;
  assign opcode_go      = go_reg;
  assign token_send_ok  = tok_ok_reg;
  assign token_timeout  = tmo_reg;
  assign xoff_allowed   = xok_reg;
  assign cmd_ready      = ready_reg;
  assign ignore_traffic = ign_reg;
  assign resp_late      = rlate_reg;
  assign delayed_late   = dlate_reg;
  assign opcode_late    = olate_reg;
endmodule
